// File: hdl/wwt_window_watchdog.v
/*
 * Windowed watchdog with programmable upper and lower limits, limit registers for two analog
 * inputs and die temperature, and the access-path select register.
 * Assumes a decoded register write port from the serial front end (SPI or UART break), with a
 * flag saying which path carried the write, and results from the diagnostic converter.
 */
`timescale 1ns/1ps
`include "wwt_map.vh"

// Functional notes
// RULE1: Limits counted in 1200 Hz ticks
// RULE2: Upper code picks 64..6144 ticks, reset 3
// RULE3: Error when count exceeds upper limit
// RULE4: Lower code: off, 64, 128, 512 ticks
// RULE5: With lower limit, only this register restarts
// RULE6: Servicing outside window raises error
// RULE7: Without lower limit, any write restarts
// RULE8: Same behaviour on SPI and UART break
// RULE9: Bit 0 enables watchdog, off at reset
// RULE10: High limit padded with ones, greater faults
// RULE11: Low limit padded with zeros, less faults
// RULE12: Separate limits for three channels
// RULE13: Limits reset to high ones, low zero
// RULE14: Path bit: 0 SPI, 1 UART break
// RULE15: Path register writable only over UART break
// RULE16: Timeout action from shared action field
// RULE17: Action codes none, clear, alarm, high-Z
// RULE18: Each channel raises its own fault
// RULE19: Counter advances per tick, clears, held off

module wwt_window_watchdog
#(
    parameter TICK_CYCLES = `WWT_TICK_CYCLES // Core clocks per 1200 Hz tick
)
(
    input wire ref_clk, // 250 MHz clock
    input wire rst_n, // Synchronous reset, active low
    input wire reg_wr, // Register write strobe, one cycle
    input wire reg_rd, // Register read strobe, one cycle
    input wire [7:0] reg_addr, // Register address
    input wire [15:0] reg_wdata, // Write data
    input wire reg_via_uart, // Access came over UART break
    output reg [15:0] reg_rdata_q, // Read data, valid cycle after reg_rd
    output reg reg_rvalid_q, // Read data valid pulse
    input wire [15:0] alarm_action, // Alarm action register contents
    input wire analog_input_zero_valid, // Analog input zero result strobe
    input wire [11:0] analog_input_zero_result, // Analog input zero result
    input wire analog_input_one_valid, // Analog input one result strobe
    input wire [11:0] analog_input_one_result, // Analog input one result
    input wire temp_valid, // Die temperature result strobe
    input wire [11:0] temp_result, // Die temperature result
    output reg timeout_error_q, // Watchdog error pulse
    output wire [1:0] crc_timeout_action, // Action to take on watchdog error
    output wire [2:0] high_fault, // High faults: temp, input one, input zero
    output wire [2:0] low_fault, // Low faults: temp, input one, input zero
    output wire uart_break_access // Register map served by UART break
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function [12:0] upper_ticks;
        input [2:0] code;
        begin
            case (code) // RULE2
                3'h0: upper_ticks = `WWT_UP0;
                3'h1: upper_ticks = `WWT_UP1;
                3'h2: upper_ticks = `WWT_UP2;
                3'h3: upper_ticks = `WWT_UP3;
                3'h4: upper_ticks = `WWT_UP4;
                3'h5: upper_ticks = `WWT_UP5;
                3'h6: upper_ticks = `WWT_UP6;
                default: upper_ticks = `WWT_UP7;
            endcase
        end
    endfunction

    function [12:0] lower_ticks;
        input [1:0] code;
        begin
            case (code) // RULE4
                2'h1: lower_ticks = `WWT_UP0;
                2'h2: lower_ticks = `WWT_UP1;
                2'h3: lower_ticks = `WWT_UP2;
                default: lower_ticks = 13'h0000;
            endcase
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg [15:0] window_timer_q;
    reg [15:0] analog_in_zero_limits_q;
    reg [15:0] analog_in_one_limits_q;
    reg [15:0] temp_limits_q;
    reg [15:0] path_select_q;

    wire timer_enable_bit;
    wire [1:0] lower_limit_code;
    wire [2:0] upper_limit_code;
    wire wr_timer;

    assign timer_enable_bit = window_timer_q[`WWT_ENABLE_BIT]; // RULE9
    assign lower_limit_code = window_timer_q[`WWT_LOWER_MSB:`WWT_LOWER_LSB];
    assign upper_limit_code = window_timer_q[`WWT_UPPER_MSB:`WWT_UPPER_LSB];
    assign wr_timer = reg_wr && (reg_addr == `WWT_ADDR_WINDOW_TIMER);
    assign uart_break_access = path_select_q[0]; // RULE14

    // Writes from either path land here alike
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            window_timer_q <= `WWT_RST_WINDOW_TIMER; // RULE9
            analog_in_zero_limits_q <= `WWT_RST_LIMITS; // RULE13
            analog_in_one_limits_q <= `WWT_RST_LIMITS; // RULE13
            temp_limits_q <= `WWT_RST_LIMITS; // RULE13
        end
        else if (reg_wr)
        begin
            case (reg_addr) // RULE8
                `WWT_ADDR_WINDOW_TIMER: window_timer_q <= reg_wdata & `WWT_WINDOW_TIMER_MASK;
                `WWT_ADDR_ANALOG_IN_ZERO_LIMITS: analog_in_zero_limits_q <= reg_wdata; // RULE12
                `WWT_ADDR_ANALOG_IN_ONE_LIMITS: analog_in_one_limits_q <= reg_wdata; // RULE12
                `WWT_ADDR_TEMP_LIMITS: temp_limits_q <= reg_wdata; // RULE12
                default: window_timer_q <= window_timer_q;
            endcase
        end
    end

    // Path register follows break-mode writes only; an SPI write to it is dropped
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            path_select_q <= `WWT_RST_PATH_SELECT; // RULE14
        else if (reg_wr && reg_via_uart && (reg_addr == `WWT_ADDR_PATH_SELECT)) // RULE15
            path_select_q <= {15'h0000, reg_wdata[0]};
    end

    // Reserved bits read as zero; unmapped addresses read as zero
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
            begin
                case (reg_addr)
                    `WWT_ADDR_WINDOW_TIMER: reg_rdata_q <= window_timer_q;
                    `WWT_ADDR_ANALOG_IN_ZERO_LIMITS: reg_rdata_q <= analog_in_zero_limits_q;
                    `WWT_ADDR_ANALOG_IN_ONE_LIMITS: reg_rdata_q <= analog_in_one_limits_q;
                    `WWT_ADDR_TEMP_LIMITS: reg_rdata_q <= temp_limits_q;
                    `WWT_ADDR_PATH_SELECT: reg_rdata_q <= path_select_q;
                    default: reg_rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // ****************************************
    // Tick prescaler
    // ****************************************
    // Core-clock stand-in for the oscillator divided by 1024
    reg [17:0] presc_q;
    wire tick;

    assign tick = (presc_q == TICK_CYCLES[17:0] - 18'h00001); // RULE1

    always @(posedge ref_clk)
    begin
        if (!rst_n || !timer_enable_bit)
            presc_q <= 18'h00000;
        else if (tick)
            presc_q <= 18'h00000;
        else
            presc_q <= presc_q + 18'h00001; // RULE1
    end

    // ****************************************
    // Watchdog counter and window check
    // ****************************************
    reg [12:0] count_q;
    reg [12:0] count_d;
    reg expired_q;
    reg expired_d;
    reg timeout_error_d;
    wire window_on;
    wire at_limit;
    wire [12:0] up_lim;

    assign window_on = (lower_limit_code != 2'h0);
    assign up_lim = upper_ticks(upper_limit_code);
    assign at_limit = (count_q == up_lim) && !expired_q;

    // ****************************************
    // Service write qualification
    // ****************************************
    // A write that turns the watchdog off is neither judged nor an error
    reg service_wr;
    reg restart;
    reg early;
    reg late;
    reg [12:0] low_lim;

    always @*
    begin
        low_lim = lower_ticks(lower_limit_code);
        service_wr = window_on ? wr_timer : reg_wr; // RULE5 RULE7
        restart = timer_enable_bit && service_wr;
        early = 1'b0;
        late = 1'b0;
        // Judged against the window in force before this write
        if (restart && window_on && reg_wdata[`WWT_ENABLE_BIT])
        begin
            early = (count_q < low_lim); // RULE6
            late = expired_q; // RULE6
        end
    end

    // ****************************************
    // Watchdog counter
    // ****************************************
    // Restart wins over a tick in the same cycle
    always @*
    begin
        count_d = count_q;
        expired_d = expired_q;
        timeout_error_d = 1'b0;
        if (restart)
        begin
            count_d = 13'h0000; // RULE19
            expired_d = 1'b0;
            timeout_error_d = early || late; // RULE6
        end
        else if (tick)
        begin
            // Saturate past the limit so one expiry gives one error pulse
            if (at_limit)
            begin
                expired_d = 1'b1;
                timeout_error_d = 1'b1; // RULE3
            end
            if (!expired_q)
                count_d = count_q + 13'h0001; // RULE19
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n || !timer_enable_bit)
        begin
            count_q <= 13'h0000; // RULE19
            expired_q <= 1'b0;
            timeout_error_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            expired_q <= expired_d;
            timeout_error_q <= timeout_error_d;
        end
    end

    assign crc_timeout_action = alarm_action[`WWT_ACTION_MSB:`WWT_ACTION_LSB]; // RULE16 RULE17

    // ****************************************
    // Channel limit checks
    // ****************************************
    wire [15:0] lim_bus [0:2];
    wire [2:0] val_bus;
    wire [11:0] res_bus [0:2];

    assign lim_bus[0] = analog_in_zero_limits_q;
    assign lim_bus[1] = analog_in_one_limits_q;
    assign lim_bus[2] = temp_limits_q;
    assign val_bus = {temp_valid, analog_input_one_valid, analog_input_zero_valid};
    assign res_bus[0] = analog_input_zero_result;
    assign res_bus[1] = analog_input_one_result;
    assign res_bus[2] = temp_result;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_chan
            wire high_w;
            wire low_w;
            wwt_limit_check u_check
            (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .limits(lim_bus[gi]),
                .result_valid(val_bus[gi]),
                .result(res_bus[gi]),
                .high_fault_q(high_w),
                .low_fault_q(low_w)
            );
            assign high_fault[gi] = high_w; // RULE18
            assign low_fault[gi] = low_w; // RULE18
        end
    endgenerate

endmodule

// File: hdl/wwt_map.vh
/*
 * Register offsets, field positions, reset values and timing counts of the windowed watchdog and
 * limit block. Assumes inclusion by bare name from the design files.
 */
`ifndef WWT_MAP_VH
`define WWT_MAP_VH

// ****************************************
// Register offsets (8-bit register address)
// ****************************************
`define WWT_ADDR_WINDOW_TIMER 8'h11
`define WWT_ADDR_ANALOG_IN_ZERO_LIMITS 8'h12
`define WWT_ADDR_ANALOG_IN_ONE_LIMITS 8'h13
`define WWT_ADDR_TEMP_LIMITS 8'h14
`define WWT_ADDR_PATH_SELECT 8'h16
`define WWT_ADDR_ALARM_ACTION 8'h10

// ****************************************
// Reset values
// ****************************************
`define WWT_RST_WINDOW_TIMER 16'h0018
`define WWT_RST_LIMITS 16'hFF00
`define WWT_RST_PATH_SELECT 16'h0000

// ****************************************
// Field positions
// ****************************************
`define WWT_ENABLE_BIT 0
`define WWT_LOWER_LSB 1
`define WWT_LOWER_MSB 2
`define WWT_UPPER_LSB 3
`define WWT_UPPER_MSB 5
`define WWT_WINDOW_TIMER_MASK 16'h003F
`define WWT_HIGH_LSB 8
`define WWT_HIGH_MSB 15
`define WWT_LOW_LSB 0
`define WWT_LOW_MSB 7
`define WWT_ACTION_LSB 6
`define WWT_ACTION_MSB 7

// ****************************************
// Timing
// ****************************************
`define WWT_OSC_HZ 1228800
`define WWT_TICK_DIV 1024
`define WWT_TICK_HZ 1200
`define WWT_CLK_HZ 250000000
`define WWT_TICK_CYCLES (`WWT_CLK_HZ / `WWT_TICK_HZ)

// Tick counts selected by the limit codes
`define WWT_UP0 13'h0040
`define WWT_UP1 13'h0080
`define WWT_UP2 13'h0200
`define WWT_UP3 13'h0400
`define WWT_UP4 13'h0800
`define WWT_UP5 13'h0C00
`define WWT_UP6 13'h1000
`define WWT_UP7 13'h1800

// Fault action codes
`define WWT_ACT_NONE 2'h0
`define WWT_ACT_CLEAR 2'h1
`define WWT_ACT_ALARM_V 2'h2
`define WWT_ACT_HIZ 2'h3

`endif

// File: hdl/wwt_limit_check.v
/*
 * Window comparison of one 12-bit diagnostic result against a packed limit register.
 * Assumes the result and its valid strobe are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "wwt_map.vh"

module wwt_limit_check
(
    input wire ref_clk, // Clock
    input wire rst_n, // Synchronous reset, active low
    input wire [15:0] limits, // High field [15:8], low field [7:0]
    input wire result_valid, // Result strobe
    input wire [11:0] result, // Conversion result
    output reg high_fault_q, // Result above high limit
    output reg low_fault_q // Result below low limit
);

    wire [11:0] high_limit;
    wire [11:0] low_limit;

    assign high_limit = {limits[`WWT_HIGH_MSB:`WWT_HIGH_LSB], 4'hF}; // RULE10
    assign low_limit = {limits[`WWT_LOW_MSB:`WWT_LOW_LSB], 4'h0}; // RULE11

    // Flags follow the latest result; they do not latch across results
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            high_fault_q <= 1'b0;
            low_fault_q <= 1'b0;
        end
        else if (result_valid)
        begin
            high_fault_q <= (result > high_limit); // RULE10
            low_fault_q <= (result < low_limit); // RULE11
        end
    end

endmodule

// File: test/wwt_window_monitor.sv
/* Port checker for the windowed watchdog and limit block.
   Assumes a bind onto wwt_window_watchdog with its tick parameter. */
`timescale 1ns/1ps
module wwt_window_monitor
#(
    parameter TICK_CYCLES = 4 // Clocks per tick
)
(
    input logic ref_clk, // Clock
    input logic rst_n, // Reset, active low
    input logic reg_wr, // Write strobe
    input logic [7:0] reg_addr, // Address
    input logic [15:0] reg_wdata, // Write data
    input logic reg_via_uart, // Break path flag
    input logic [15:0] alarm_action, // Action register
    input logic analog_input_zero_valid, // Strobe
    input logic [11:0] analog_input_zero_result, // Result
    input logic temp_valid, // Strobe
    input logic [11:0] temp_result, // Result
    input logic timeout_error_q, // Error pulse
    input logic [1:0] crc_timeout_action, // Action out
    input logic [2:0] high_fault, // High flags
    input logic [2:0] low_fault, // Low flags
    input logic uart_break_access // Path bit
);
    // Slack covers prescaler restart and the extra tick
    localparam int T_MIN = 64 * TICK_CYCLES;
    localparam int T_MAX = 66 * TICK_CYCLES + 4;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_arm;
        reg_wr && reg_addr == 8'h11 && reg_wdata[5:0] == 6'h01;
    endsequence
    sequence s_path(u);
        reg_wr && reg_addr == 8'h16 && reg_via_uart == u;
    endsequence
    property p_arm;
        s_arm |-> ##[T_MIN:T_MAX] timeout_error_q;
    endproperty
    a_arm: assert property (p_arm) else $error("no timeout after arming");
    property p_off;
        reg_wr && reg_addr == 8'h11 && !reg_wdata[0] |=> !timeout_error_q [*8];
    endproperty
    a_off: assert property (p_off) else $error("error while disabled");
    property p_rst;
        $rose(rst_n) |-> !timeout_error_q [*8];
    endproperty
    a_rst: assert property (p_rst) else $error("error after reset");
    property p_act;
        crc_timeout_action == alarm_action[7:6];
    endproperty
    a_act: assert property (p_act) else $error("action field mismatch");
    property p_spi;
        s_path(1'b0) |=> $stable(uart_break_access);
    endproperty
    a_spi: assert property (p_spi) else $error("path changed by spi");
    property p_uart;
        s_path(1'b1) ##0 reg_wdata[0] |=> uart_break_access;
    endproperty
    a_uart: assert property (p_uart) else $error("path not set");
    // Limit register mirrors, rebuilt from the writes seen on the port
    logic [15:0] zero_lim_q;
    logic [15:0] temp_lim_q;
    always @(posedge ref_clk)
    begin
        if (!rst_n || (reg_wr && reg_addr == 8'h12))
            zero_lim_q <= rst_n ? reg_wdata : 16'hFF00;
        if (!rst_n || (reg_wr && reg_addr == 8'h14))
            temp_lim_q <= rst_n ? reg_wdata : 16'hFF00;
    end
    property p_high0;
        analog_input_zero_valid |=> high_fault[0] == $past(analog_input_zero_result > {zero_lim_q[15:8], 4'hF});
    endproperty
    a_high0: assert property (p_high0) else $error("input zero high flag wrong");
    property p_low0;
        analog_input_zero_valid |=> low_fault[0] == $past(analog_input_zero_result < {zero_lim_q[7:0], 4'h0});
    endproperty
    a_low0: assert property (p_low0) else $error("input zero low flag wrong");
    property p_temp;
        temp_valid |=> high_fault[2] == $past(temp_result > {temp_lim_q[15:8], 4'hF});
    endproperty
    a_temp: assert property (p_temp) else $error("temp high flag wrong");
endmodule

// File: test/wwt_host_model.sv
/* Host controller model driving the register port.
   Assumes the bench runs ref_clk. */
`timescale 1ns/1ps
module wwt_host_model
(
    input logic ref_clk, // Clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Address
    output logic [15:0] reg_wdata, // Write data
    output logic reg_via_uart, // Break path flag
    input logic [15:0] reg_rdata_q, // Read data
    input logic reg_rvalid_q // Read valid
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_via_uart = 1'b0;
    end
    // Released lines invert so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic u);
        @(posedge ref_clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        reg_via_uart = u;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        for (int n = 0; n < 4 && reg_rvalid_q !== 1'b1; n++)
            @(posedge ref_clk) #1;
        d = reg_rvalid_q ? reg_rdata_q : 16'hXXXX;
    endtask
endmodule

// File: test/tb_top.sv
/* Self-checking bench for the watchdog and limit block.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    localparam int TC = 4;
    localparam logic [7:0] RA [6] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h15};
    localparam logic [15:0] RV [6] = '{16'h0018, 16'hFF00, 16'hFF00, 16'hFF00, 16'h0000, 16'h0000};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_via_uart, reg_rvalid_q, timeout_error_q, uart_break_access;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q;
    logic [15:0] alarm_action = 16'h0000;
    logic [2:0] vld = 3'h0;
    logic [2:0] high_fault, low_fault;
    logic [11:0] res [3] = '{default: 12'h000};
    logic [1:0] crc_timeout_action;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int errs = 0;
    int t0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (timeout_error_q === 1'b1)
            errs++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    wwt_host_model i_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_via_uart(reg_via_uart), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
    wwt_window_watchdog #(.TICK_CYCLES(TC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_via_uart(reg_via_uart),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .alarm_action(alarm_action),
        .analog_input_zero_valid(vld[0]), .analog_input_zero_result(res[0]),
        .analog_input_one_valid(vld[1]), .analog_input_one_result(res[1]),
        .temp_valid(vld[2]), .temp_result(res[2]), .timeout_error_q(timeout_error_q),
        .crc_timeout_action(crc_timeout_action), .high_fault(high_fault), .low_fault(low_fault),
        .uart_break_access(uart_break_access));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n * TC) @(posedge ref_clk);
    endtask
    task automatic apply(input int c, input logic [11:0] v);
        @(posedge ref_clk) #1;
        vld[c] = 1'b1;
        res[c] = v;
        @(posedge ref_clk) #1;
        vld[c] = 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        foreach (RA[i]) rdchk(RA[i], RV[i]);
        $display("test reset values done");
        for (int c = 0; c < 3; c++)
        begin
            apply(c, 12'hFFF);
            chk("high default", high_fault[c], 1'b0);
            apply(c, 12'h000);
            chk("low default", low_fault[c], 1'b0);
            i_host.wr(8'(8'h12 + c), 16'h8020, 1'b0);
            apply(c, 12'h810);
            chk("high over", high_fault[c], 1'b1);
            chk("others", 16'(high_fault & ~(3'h1 << c)), 16'h0000);
            apply(c, 12'h80F);
            chk("high at", high_fault[c], 1'b0);
            apply(c, 12'h1FF);
            chk("low under", low_fault[c], 1'b1);
            apply(c, 12'h200);
            chk("low at", low_fault[c], 1'b0);
        end
        $display("test limits done");
        for (int a = 0; a < 4; a++)
        begin
            @(posedge ref_clk) #1;
            alarm_action = {8'hA5, 2'(a), 6'h15};
            #1 chk("action", crc_timeout_action, 16'(a));
        end
        i_host.wr(8'h16, 16'h0001, 1'b0);
        chk("spi path", uart_break_access, 1'b0);
        i_host.wr(8'h16, 16'h0001, 1'b1);
        rdchk(8'h16, 16'h0001);
        i_host.wr(8'h16, 16'h0000, 1'b0);
        chk("spi clear", uart_break_access, 1'b1);
        i_host.wr(8'h16, 16'hFFFE, 1'b1);
        rdchk(8'h16, 16'h0000);
        i_host.wr(8'h11, 16'hFFFF, 1'b0);
        rdchk(8'h11, 16'h003F);
        i_host.wr(8'h11, 16'h0018, 1'b0);
        $display("test path and action done");
        t0 = errs;
        i_host.wr(8'h11, 16'h0001, 1'b0);
        for (int n = 0; n < 400 && timeout_error_q !== 1'b1; n++)
            @(posedge ref_clk) #1;
        chk("timeout", 16'(errs == t0 && timeout_error_q === 1'b1), 16'h0001);
        ticks(40);
        chk("one pulse", 16'(errs - t0), 16'h0001);
        i_host.wr(8'h11, 16'h0009, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            ticks(100);
            i_host.wr(8'h12, 16'h8020, k[0]);
        end
        ticks(100);
        chk("any restart", 16'(errs - t0), 16'h0001);
        i_host.wr(8'h11, 16'h000B, 1'b0);
        ticks(100);
        i_host.wr(8'h11, 16'h000B, 1'b1);
        ticks(10);
        chk("in window", 16'(errs - t0), 16'h0001);
        i_host.wr(8'h11, 16'h000B, 1'b0);
        ticks(1);
        chk("early", 16'(errs - t0), 16'h0002);
        ticks(100);
        i_host.wr(8'h12, 16'h8020, 1'b0);
        ticks(40);
        chk("no restart", 16'(errs - t0), 16'h0003);
        i_host.wr(8'h11, 16'h000B, 1'b1);
        ticks(1);
        chk("late", 16'(errs - t0), 16'h0004);
        i_host.wr(8'h11, 16'h0018, 1'b0);
        ticks(200);
        chk("disabled", 16'(errs - t0), 16'h0004);
        $display("test watchdog done");
        end_of_test();
    end
endmodule
bind wwt_window_watchdog wwt_window_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_via_uart(reg_via_uart),
    .alarm_action(alarm_action), .analog_input_zero_valid(analog_input_zero_valid),
    .analog_input_zero_result(analog_input_zero_result), .temp_valid(temp_valid),
    .temp_result(temp_result), .timeout_error_q(timeout_error_q), .crc_timeout_action(crc_timeout_action),
    .high_fault(high_fault), .low_fault(low_fault), .uart_break_access(uart_break_access));
